// File: design/usbep_endpoint_manager.sv
// Functional notes
// - Four endpoint numbers, receive and transmit each
// - Each direction configured on its own
// - Endpoint 0 always control, both directions
// - Other endpoints disabled after reset
// - One control word: low receive, high transmit
// - Type codes 00/01/10/11; init word layout
// - Stall bit forces STALL until cleared
// - Setup on control clears stalls, answers ACK
// - Setup to non-control: STALL, bit unchanged
// - IN/OUT/PING: STALL if stalled, else normal
// - Toggle reset bit restarts toggle sequence
// - Toggle inhibit accepts every data packet
// - Toggle mismatch: discard silently, still ACK
// - Priming fetches descriptor, keeps a copy; receive priming here only marks ready
// - Leading data staged in per-endpoint channels
// - Primed shown in status when priming ends
// - Flush removes queued packet on direction
// - Each transmit channel 128 by 36 dual-port
// - Unprimed bulk or interrupt answers NAK
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module usbep_endpoint_manager
    import usbep_pkg::*;
#(
    parameter int N_EP  = NUM_EP,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int LEAD  = LEAD_WORDS
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata,
    output logic               mem_req,
    output logic [31:0]        mem_addr,
    input  wire logic          mem_ack,
    input  wire logic [31:0]   mem_rdata,
    input  wire usbep_tok_t    tok,
    output usbep_resp_t        resp,
    input  wire logic          tx_pop,
    input  wire logic [1:0]    tx_pop_ep,
    output logic [35:0]        tx_word,
    output logic [N_EP-1:0]    tx_avail
);

    localparam int CW = $clog2(DEPTH) + 1;

    typedef enum logic [2:0] {
        FS_IDLE, FS_QH, FS_TD_TOT, FS_TD_BUF, FS_FILL
    } usbep_fsm_t;

    typedef struct packed {
        usbep_dir_t [N_EP-1:0]        rx_cfg;
        usbep_dir_t [N_EP-1:0]        tx_cfg;
        logic [N_EP-1:0]              rx_tgl;
        logic [N_EP-1:0]              tx_tgl;
        logic [N_EP-1:0]              rx_primed;
        logic [N_EP-1:0]              tx_primed;
        logic [N_EP-1:0]              pend;
        logic [31:0]                  qh_base;
        usbep_fsm_t                   fsm;
        logic [1:0]                   cur;
        logic                         lead;
        logic                         abort;
        logic [31:0]                  ptr;
        logic [31:0]                  maddr;
        logic [N_EP-1:0][15:0]        left;
        logic [N_EP-1:0][31:0]        buf_ptr;
        logic [31:0]                  rdata;
        usbep_resp_t                  resp;
    } usbep_state_t;

    usbep_state_t          st;
    usbep_state_t          next_st;
    usbep_state_t          rst_st;
    logic [N_EP-1:0]       f_wr_valid;
    logic [N_EP-1:0]       f_wr_ready;
    logic [N_EP-1:0]       f_rd_valid;
    logic [N_EP-1:0]       f_rd_ready;
    logic [N_EP-1:0]       f_flush;
    logic [35:0]           f_rd_data [N_EP];
    logic [CW-1:0]         f_count [N_EP];
    logic [35:0]           f_wr_data;
    logic [3:0]            lanes;
    logic [N_EP-1:0]       flush_rx;
    logic [N_EP-1:0]       flush_tx;
    logic                  wr_flush;

    // Reset state
    // Everything clear except endpoint 0, which stays a control pair
    always_comb begin
        rst_st = '0;
        for (int i = 0; i < N_EP; i++) begin
            rst_st.rx_cfg[i] = DIR_RESET;
            rst_st.tx_cfg[i] = DIR_RESET;
        end
        rst_st.rx_cfg[0] = EP0_RESET;
        rst_st.tx_cfg[0] = EP0_RESET;
    end

    // Flush requests decoded straight from the write strobe
    assign wr_flush = reg_wr && (reg_addr == OFS_FLUSH);
    assign flush_rx = wr_flush ? reg_wdata[N_EP-1:0] : '0;
    assign flush_tx = wr_flush ? reg_wdata[F_TX_HALF +: N_EP] : '0;

    // Byte lanes of the word being staged; a short tail fills low lanes
    always_comb begin
        unique case (st.left[st.cur])
            16'h0001: lanes = 4'h1;
            16'h0002: lanes = 4'h3;
            16'h0003: lanes = 4'h7;
            default:  lanes = 4'hf;
        endcase
    end
    assign f_wr_data = {lanes, mem_rdata};

    // Staging channels
    // One virtual channel per transmit endpoint
    for (genvar g = 0; g < N_EP; g++) begin : g_chan
        assign f_wr_valid[g] = (st.fsm == FS_FILL) && mem_ack
                               && !st.abort && (st.cur == 2'(g));
        assign f_rd_ready[g] = tx_pop && (tx_pop_ep == 2'(g));
        assign f_flush[g]    = flush_tx[g];
        assign tx_avail[g]   = f_rd_valid[g] && st.tx_primed[g];
        usbep_stage_fifo #(
            .WIDTH (FIFO_WIDTH),
            .DEPTH (DEPTH),
            .AW    ($clog2(DEPTH))
        ) u_chan (
            .mclk     (mclk),
            .rst      (rst),
            .flush    (f_flush[g]),
            .wr_valid (f_wr_valid[g]),
            .wr_ready (f_wr_ready[g]),
            .wr_data  (f_wr_data),
            .rd_valid (f_rd_valid[g]),
            .rd_ready (f_rd_ready[g]),
            .rd_data  (f_rd_data[g]),
            .count    (f_count[g])
        );
    end

    assign tx_word   = f_rd_data[tx_pop_ep];
    assign mem_req   = (st.fsm != FS_IDLE);
    assign mem_addr  = st.maddr;
    assign reg_rdata = st.rdata;
    assign resp      = st.resp;

    // Next-state logic: tokens, then fetch engine, then software
    always_comb begin
        logic [1:0]  e;
        usbep_dir_t  rxc;
        usbep_dir_t  txc;
        logic        ctl;
        logic        tgl_ok;
        logic [1:0]  w;
        logic [15:0] take;
        next_st = st;
        e = tok.ep;
        rxc = st.rx_cfg[e];
        txc = st.tx_cfg[e];
        ctl = (rxc.ep_type == EP_CONTROL);
        tgl_ok = 1'b0;
        w = reg_addr[3:2];
        take = '0;
        next_st.resp = '0;
        next_st.rdata = '0;

        // Token handling; the answer stands one cycle after the token
        if (tok.valid) begin
            next_st.resp.valid = (tok.kind != TK_HOST_ACK);
            unique case (tok.kind)
                TK_SETUP: begin
                    if (ctl) begin
                        next_st.rx_cfg[e].stall = 1'b0;
                        next_st.tx_cfg[e].stall = 1'b0;
                        next_st.rx_tgl[e] = 1'b1;
                        next_st.tx_tgl[e] = 1'b1;
                        next_st.resp.code = HS_ACK;
                        next_st.resp.accept = 1'b1;
                    end else begin
                        next_st.resp.code = HS_STALL;
                    end
                end
                TK_IN: begin
                    if (!txc.enable) begin
                        next_st.resp.code = HS_NONE;
                    end else if (txc.stall) begin
                        next_st.resp.code = HS_STALL;
                    end else if (st.tx_primed[e] && f_rd_valid[e]) begin
                        next_st.resp.code = HS_DATA;
                        next_st.resp.dpid = st.tx_tgl[e];
                    end else if (!st.tx_primed[e]) begin
                        next_st.resp.code = HS_NAK;
                    end else begin
                        // Underflow: stay silent, host times out
                        next_st.resp.code = HS_NONE;
                    end
                end
                TK_OUT, TK_PING: begin
                    tgl_ok = rxc.inhibit || (tok.dpid == st.rx_tgl[e]);
                    if (!rxc.enable) begin
                        next_st.resp.code = HS_NONE;
                    end else if (rxc.stall) begin
                        next_st.resp.code = HS_STALL;
                    end else if (!st.rx_primed[e]) begin
                        next_st.resp.code = HS_NAK;
                    end else if (tok.kind == TK_PING) begin
                        next_st.resp.code = HS_ACK;
                    end else begin
                        next_st.resp.code = HS_ACK;
                        next_st.resp.accept = tgl_ok;
                        if (tgl_ok && !rxc.inhibit) begin
                            next_st.rx_tgl[e] = ~st.rx_tgl[e];
                        end
                    end
                end
                TK_HOST_ACK: begin
                    // Host took the IN packet: advance toggle
                    next_st.tx_tgl[e] = ~st.tx_tgl[e];
                    if (st.left[e] == '0 && !f_rd_valid[e]) begin
                        next_st.tx_primed[e] = 1'b0;
                    end
                end
                default: next_st.resp = '0;
            endcase
        end

        unique case (st.fsm)
            FS_IDLE: begin
                next_st.abort = 1'b0;
                if (st.pend != '0) begin
                    for (int i = N_EP - 1; i >= 0; i--) begin
                        if (st.pend[i]) next_st.cur = 2'(i);
                    end
                    next_st.pend[next_st.cur] = 1'b0;
                    next_st.lead = 1'b1;
                    next_st.maddr = st.qh_base + QH_NEXT_OFS
                        + QH_STRIDE * {29'h0, next_st.cur, 1'b1};
                    next_st.fsm = FS_QH;
                end else begin
                    for (int i = N_EP - 1; i >= 0; i--) begin
                        if (st.tx_primed[i] && st.left[i] != '0
                            && f_wr_ready[i]) begin
                            next_st.cur = 2'(i);
                            next_st.lead = 1'b0;
                            next_st.maddr = st.buf_ptr[i];
                            next_st.fsm = FS_FILL;
                        end
                    end
                end
            end
            FS_QH: begin
                if (mem_ack) begin
                    next_st.ptr = mem_rdata;
                    next_st.maddr = mem_rdata + DTD_TOT_OFS;
                    next_st.fsm = st.abort ? FS_IDLE : FS_TD_TOT;
                end
            end
            FS_TD_TOT: begin
                if (mem_ack) begin
                    // Local copy of the descriptor context
                    next_st.left[st.cur] = {1'b0,
                        mem_rdata[DTD_TOT_LSB +: 15]};
                    next_st.maddr = st.ptr + DTD_BUF_OFS;
                    next_st.fsm = st.abort ? FS_IDLE : FS_TD_BUF;
                end
            end
            FS_TD_BUF: begin
                if (mem_ack) begin
                    next_st.buf_ptr[st.cur] = mem_rdata;
                    next_st.maddr = mem_rdata;
                    next_st.fsm = FS_FILL;
                    if (st.abort) begin
                        next_st.fsm = FS_IDLE;
                    end else if (st.left[st.cur] == '0) begin
                        // Zero-length packet: primed with no data
                        next_st.tx_primed[st.cur] = 1'b1;
                        next_st.fsm = FS_IDLE;
                    end
                end
            end
            FS_FILL: begin
                if (mem_ack) begin
                    take = (st.left[st.cur] > WORD_BYTES)
                         ? WORD_BYTES : st.left[st.cur];
                    next_st.left[st.cur] = st.left[st.cur] - take;
                    next_st.buf_ptr[st.cur] = st.buf_ptr[st.cur]
                        + {16'h0, WORD_BYTES};
                    next_st.maddr = next_st.buf_ptr[st.cur];
                    next_st.fsm = FS_IDLE;
                    if (st.lead && !st.abort) begin
                        if (32'(f_count[st.cur]) + 1 >= LEAD
                            || next_st.left[st.cur] == '0) begin
                            next_st.tx_primed[st.cur] = 1'b1;
                        end else begin
                            next_st.fsm = FS_FILL;
                        end
                    end
                end
            end
            default: next_st.fsm = FS_IDLE;
        endcase

        // Control word write, low half receive
        if (reg_wr && reg_addr >= OFS_CTRL0 && reg_addr <= OFS_CTRL3
            && reg_addr[1:0] == 2'b00) begin
            next_st.rx_cfg[w] = '{reg_wdata[F_ENABLE],
                usbep_type_t'(reg_wdata[F_TYPE +: 2]),
                reg_wdata[F_INHIBIT], reg_wdata[F_STALL]};
            next_st.tx_cfg[w] = '{reg_wdata[F_TX_HALF + F_ENABLE],
                usbep_type_t'(reg_wdata[F_TX_HALF + F_TYPE +: 2]),
                reg_wdata[F_TX_HALF + F_INHIBIT],
                reg_wdata[F_TX_HALF + F_STALL]};
            if (reg_wdata[F_TGL_RST]) next_st.rx_tgl[w] = 1'b0;
            if (reg_wdata[F_TX_HALF + F_TGL_RST]) begin
                next_st.tx_tgl[w] = 1'b0;
            end
            if (w == 2'd0) begin
                next_st.rx_cfg[0].ep_type = EP_CONTROL;
                next_st.tx_cfg[0].ep_type = EP_CONTROL;
                next_st.rx_cfg[0].enable = 1'b1;
                next_st.tx_cfg[0].enable = 1'b1;
            end
        end

        // Prime request: receive marks ready, transmit starts a fetch
        if (reg_wr && reg_addr == OFS_PRIME) begin
            next_st.rx_primed = next_st.rx_primed
                | reg_wdata[N_EP-1:0];
            next_st.pend = next_st.pend
                | reg_wdata[F_TX_HALF +: N_EP];
        end

        for (int i = 0; i < N_EP; i++) begin
            if (flush_rx[i]) next_st.rx_primed[i] = 1'b0;
            if (flush_tx[i]) begin
                next_st.tx_primed[i] = 1'b0;
                next_st.pend[i] = 1'b0;
                next_st.left[i] = '0;
                // In-flight fetch for this endpoint is discarded
                if (next_st.fsm != FS_IDLE && st.cur == 2'(i)) begin
                    next_st.abort = 1'b1;
                end
            end
        end

        if (reg_wr && reg_addr == OFS_QH_BASE) begin
            next_st.qh_base = reg_wdata;
        end

        // Read mux; data stands the cycle after the strobe only
        if (reg_rd) begin
            if (reg_addr >= OFS_CTRL0 && reg_addr <= OFS_CTRL3
                && reg_addr[1:0] == 2'b00) begin
                next_st.rdata[F_ENABLE] = st.rx_cfg[w].enable;
                next_st.rdata[F_TYPE +: 2] = st.rx_cfg[w].ep_type;
                next_st.rdata[F_INHIBIT] = st.rx_cfg[w].inhibit;
                next_st.rdata[F_STALL] = st.rx_cfg[w].stall;
                next_st.rdata[F_TX_HALF + F_ENABLE] =
                    st.tx_cfg[w].enable;
                next_st.rdata[F_TX_HALF + F_TYPE +: 2] =
                    st.tx_cfg[w].ep_type;
                next_st.rdata[F_TX_HALF + F_INHIBIT] =
                    st.tx_cfg[w].inhibit;
                next_st.rdata[F_TX_HALF + F_STALL] =
                    st.tx_cfg[w].stall;
            end else if (reg_addr == OFS_PRIME) begin
                next_st.rdata[F_TX_HALF +: N_EP] = st.pend;
            end else if (reg_addr == OFS_STATUS) begin
                next_st.rdata[N_EP-1:0] = st.rx_primed;
                next_st.rdata[F_TX_HALF +: N_EP] = st.tx_primed;
            end else if (reg_addr == OFS_QH_BASE) begin
                next_st.rdata = st.qh_base;
            end else if (reg_addr == OFS_TOGGLE) begin
                next_st.rdata[N_EP-1:0] = st.rx_tgl;
                next_st.rdata[F_TX_HALF +: N_EP] = st.tx_tgl;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) st <= rst_st;
        else st <= next_st;
    end

endmodule

// File: design/usbep_pkg.sv
package usbep_pkg;

    // Endpoint numbers, each with a receive and a transmit direction
    localparam int NUM_EP = 4;

    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL0   = 8'h00;
    localparam logic [7:0] OFS_CTRL3   = 8'h0c;
    localparam logic [7:0] OFS_PRIME   = 8'h10;
    localparam logic [7:0] OFS_FLUSH   = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;
    localparam logic [7:0] OFS_QH_BASE = 8'h1c;
    localparam logic [7:0] OFS_TOGGLE  = 8'h20;

    // Field positions inside one half of endpoint_control
    localparam int F_STALL   = 0;
    localparam int F_TYPE    = 2;
    localparam int F_INHIBIT = 5;
    localparam int F_TGL_RST = 6;
    localparam int F_ENABLE  = 7;
    localparam int F_TX_HALF = 16;

    // Queue head and transfer descriptor layout in memory
    localparam logic [31:0] QH_STRIDE    = 32'h0000_0040;
    localparam logic [31:0] QH_NEXT_OFS  = 32'h0000_0008;
    localparam logic [31:0] DTD_TOT_OFS  = 32'h0000_0004;
    localparam logic [31:0] DTD_BUF_OFS  = 32'h0000_0008;
    localparam int          DTD_TOT_LSB  = 16;
    localparam logic [15:0] WORD_BYTES   = 16'h0004;

    // Staging FIFO shape and the amount staged before primed is shown
    localparam int FIFO_DEPTH = 128;
    localparam int FIFO_WIDTH = 36;
    localparam int LEAD_WORDS = 8;

    typedef enum logic [1:0] {
        EP_CONTROL = 2'b00,
        EP_ISO     = 2'b01,
        EP_BULK    = 2'b10,
        EP_INTR    = 2'b11
    } usbep_type_t;

    typedef enum logic [2:0] {
        TK_SETUP, TK_IN, TK_OUT, TK_PING, TK_HOST_ACK
    } usbep_kind_t;

    typedef enum logic [2:0] {
        HS_NONE, HS_ACK, HS_NAK, HS_NYET, HS_STALL, HS_DATA
    } usbep_hs_t;

    typedef struct packed {
        logic        enable;
        usbep_type_t ep_type;
        logic        inhibit;
        logic        stall;
    } usbep_dir_t;

    // Token decoded by the link logic, one cycle per token
    typedef struct packed {
        logic        valid;
        usbep_kind_t kind;
        logic [1:0]  ep;
        logic        dpid;
    } usbep_tok_t;

    // Answer to the link logic, one cycle after the token
    typedef struct packed {
        logic      valid;
        usbep_hs_t code;
        logic      dpid;
        logic      accept;
    } usbep_resp_t;

    localparam usbep_dir_t DIR_RESET = '{1'b0, EP_CONTROL, 1'b0, 1'b0};
    localparam usbep_dir_t EP0_RESET = '{1'b1, EP_CONTROL, 1'b0, 1'b0};

endpackage

// File: design/usbep_stage_fifo.sv
`timescale 1ns/1ns
module usbep_stage_fifo
    import usbep_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data,
    output logic [AW:0]           count
);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } usbep_fifo_st_t;

    usbep_fifo_st_t   st;
    usbep_fifo_st_t   next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign wr_ready = (st.cnt != (AW+1)'(DEPTH));
    assign rd_valid = (st.cnt != '0);
    assign rd_data  = mem[st.rp];
    assign count    = st.cnt;
    assign push     = wr_valid && wr_ready && !flush;
    assign pop      = rd_valid && rd_ready && !flush;

    // Pointer update; flush empties the channel at once
    always_comb begin
        next_st = st;
        if (flush) begin
            next_st = '0;
        end else begin
            if (push) next_st.wp = st.wp + 1'b1;
            if (pop) next_st.rp = st.rp + 1'b1;
            if (push && !pop) next_st.cnt = st.cnt + 1'b1;
            if (pop && !push) next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) st <= '0;
        else st <= next_st;
    end

    // Dual-port storage: one write and one read each cycle
    always_ff @(posedge mclk) begin
        if (push) mem[st.wp] <= wr_data;
    end

endmodule

// File: testbench/usbep_properties.sv
`timescale 1ns/1ns
module usbep_properties
    import usbep_pkg::*;
#(
    parameter int N_EP = NUM_EP
) (
    input wire logic            mclk,
    input wire logic            rst,
    input wire logic            reg_rd,
    input wire logic [31:0]     reg_rdata,
    input wire logic            mem_req,
    input wire logic [31:0]     mem_addr,
    input wire logic            mem_ack,
    input wire usbep_tok_t      tok,
    input wire usbep_resp_t     resp,
    input wire logic [N_EP-1:0] tx_avail
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Bound covers a full slow fetch
    sequence s_fetch_end;
        ##[1:200] !mem_req;
    endsequence
    sequence s_answered;
        tok.valid && tok.kind != TK_HOST_ACK;
    endsequence
    // Register, token and fetch timing
    a_rdata_slot: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray rdata");
    a_resp_follows: assert property (
        s_answered |=> resp.valid) else $error("token not answered");
    a_resp_cause: assert property (
        resp.valid |-> $past(tok.valid) && $past(tok.kind) != TK_HOST_ACK)
        else $error("answer without token");
    a_setup_ack: assert property (
        tok.valid && tok.kind == TK_SETUP && tok.ep == 2'h0
        |=> resp.code == HS_ACK) else $error("setup not acked");
    a_fetch_hold: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("fetch request dropped");
    a_fetch_end: assert property (
        $rose(mem_req) |-> s_fetch_end) else $error("fetch never ends");
    a_fetch_ack: assert property (
        $fell(mem_req) |-> $past(mem_ack)) else $error("fetch ended early");
    a_avail_rise: assert property (
        $rose(|tx_avail) |-> $past(mem_ack)) else $error("primed too soon");
endmodule
bind usbep_endpoint_manager usbep_properties #(.N_EP(N_EP)) u_props (
    .mclk, .rst, .reg_rd, .reg_rdata, .mem_req, .mem_addr, .mem_ack,
    .tok, .resp, .tx_avail
);

// File: testbench/usbep_mem_model.sv
`timescale 1ns/1ns
module usbep_mem_model
    import usbep_pkg::*;
(
    input wire logic    mclk,
    input wire logic    rst,
    input wire logic    slow,
    input wire logic    mem_req,
    input wire logic [31:0] mem_addr,
    output logic        mem_ack,
    output logic [31:0] mem_rdata
);
    logic [1:0] wait_cnt;
    function automatic logic [31:0] word_at(input logic [31:0] a);
        if (a < 32'h2000)
            return 32'h0000_2000;
        if (a == 32'h2004)
            return 32'h0026_0000;
        if (a == 32'h2008)
            return 32'h0000_3000;
        return a ^ 32'h5a5a_0000;
    endfunction
    // Answer after one or four cycles; idle data inverts so stale is seen
    always_ff @(posedge mclk) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (rst) begin
            wait_cnt  <= 2'h0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (!slow || wait_cnt == 2'h3) begin
                wait_cnt  <= 2'h0;
                mem_ack   <= 1'b1;
                mem_rdata <= word_at(mem_addr);
            end
        end
    end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ns
module tb
    import usbep_pkg::*;
;
    logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        mem_req, mem_ack, slow = 1'b0, tx_pop = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_rdata, rv;
    logic [1:0]  tx_pop_ep = 2'h1;
    logic [35:0] tx_word;
    logic [3:0]  tx_avail;
    logic [15:0] h;
    usbep_tok_t  tok = '0;
    usbep_resp_t resp;
    int          mismatches = 0, total_checks = 0;
    always #50 mclk = ~mclk;
    usbep_endpoint_manager dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
        .tok, .resp, .tx_pop, .tx_pop_ep, .tx_word, .tx_avail);
    usbep_mem_model mem (.mclk, .rst, .slow, .mem_req, .mem_addr,
        .mem_ack, .mem_rdata);
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [35:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_up(input logic ok);
        if (ok !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Data sampled in the slot after the read edge
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, logic [31:0] e);
        rd(a);
        chk(n, rv, e);
    endtask
    task automatic wait_st(input int b);
        rv = 32'h0;
        for (int i = 0; i < 60 && !rv[b]; i++)
            rd(OFS_STATUS);
        give_up(rv[b]);
    endtask
    task automatic tk(usbep_kind_t k, logic [1:0] e, logic d, usbep_hs_t c);
        @(posedge mclk);
        tok <= '{1'b1, k, e, d};
        @(posedge mclk);
        tok.valid <= 1'b0;
        #1 chk("resp code", resp.code, c);
    endtask
    initial begin
        #6000000 mismatches++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rdc("ctrl0", OFS_CTRL0, 32'h0080_0080);
        rdc("ctrl1", 8'h04, 32'h0);
        rdc("unmapped", 8'hfc, 32'h0);
        $display("reset test done");
        for (int t = 0; t < 4; t++) begin
            h = {8'h00, 4'h8, t[1:0], 2'b00};
            wr(8'h08, {h, h});
            rdc("ep type", 8'h08, {h, h});
        end
        wr(8'h04, 32'h00cc_00c8);
        rdc("ctrl1 cfg", 8'h04, 32'h008c_0088);
        tk(TK_IN, 2'h1, 1'b0, HS_NAK);
        wr(8'h04, 32'h008d_0089);
        tk(TK_OUT, 2'h1, 1'b0, HS_STALL);
        tk(TK_PING, 2'h1, 1'b0, HS_STALL);
        tk(TK_SETUP, 2'h1, 1'b0, HS_STALL);
        rdc("stall kept", 8'h04, 32'h008d_0089);
        wr(8'h04, 32'h008c_0088);
        tk(TK_SETUP, 2'h1, 1'b0, HS_STALL);
        wr(OFS_CTRL0, 32'h0081_0081);
        tk(TK_IN, 2'h0, 1'b0, HS_STALL);
        tk(TK_SETUP, 2'h0, 1'b0, HS_ACK);
        rdc("stall clear", OFS_CTRL0, 32'h0080_0080);
        $display("stall test done");
        wr(OFS_QH_BASE, 32'h0000_1000);
        wr(OFS_PRIME, 32'h0000_0002);
        wait_st(1);
        tk(TK_OUT, 2'h1, 1'b0, HS_ACK);
        tk(TK_OUT, 2'h1, 1'b0, HS_ACK);
        chk("dup accept", resp.accept, 1'b0);
        wr(8'h04, 32'h008c_00c8);
        tk(TK_OUT, 2'h1, 1'b0, HS_ACK);
        chk("reset accept", resp.accept, 1'b1);
        wr(8'h04, 32'h008c_00a8);
        tk(TK_OUT, 2'h1, 1'b0, HS_ACK);
        chk("inhibit accept", resp.accept, 1'b1);
        $display("toggle test done");
        slow <= 1'b1;
        wr(OFS_PRIME, 32'h0002_0000);
        wait_st(17);
        tk(TK_IN, 2'h1, 1'b0, HS_DATA);
        for (int i = 0; i < 10; i++) begin
            for (int j = 0; j < 80 && tx_avail[1] !== 1'b1; j++)
                @(posedge mclk) #1;
            give_up(tx_avail[1]);
            chk("tx word", tx_word, {i == 9 ? 4'h3 : 4'hf,
                32'h5a5a_3000 + 32'(4 * i)});
            @(posedge mclk);
            tx_pop <= 1'b1;
            @(posedge mclk);
            tx_pop <= 1'b0;
            #1;
        end
        wr(OFS_FLUSH, 32'h0002_0000);
        rd(OFS_STATUS);
        chk("flushed", {rv[17], tx_avail[1]}, 2'b00);
        tk(TK_HOST_ACK, 2'h1, 1'b0, HS_NONE);
        rdc("toggles", OFS_TOGGLE, 32'h0003_0003);
        $display("transmit test done");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdc("ctrl1 again", 8'h04, 32'h0);
        rdc("status again", OFS_STATUS, 32'h0);
        rdc("toggle again", OFS_TOGGLE, 32'h0);
        $display("reset 2 test done");
        print_verdict();
    end
endmodule
